// ### common/gpio_pwm_pkg.sv
// Constants shared by the dual GPIO/PWM port block.
// Assumes byte-wide I/O port and configuration space accesses from the host.
package gpio_pwm_pkg;
    // I/O port addresses
    localparam logic [15:0] IO_DATA0 = 16'h0078;
    localparam logic [15:0] IO_DATA1 = 16'h0079;
    localparam logic [15:0] IO_DIR0 = 16'h0098;
    localparam logic [15:0] IO_DIR1 = 16'h0099;
    localparam logic [15:0] IO_LED = 16'h01ED;
    // Configuration space: interrupt block of port 0 and port 1
    localparam logic [7:0] CFG_P0_BASE = 8'hDC;
    localparam logic [7:0] CFG_P1_BASE = 8'hE0;
    localparam logic [1:0] CFG_MASK = 2'h0;
    localparam logic [1:0] CFG_LEVEL = 2'h1;
    localparam logic [1:0] CFG_PERIOD = 2'h2;
    localparam logic [1:0] CFG_ROUTE = 2'h3;
    // Configuration space: PWM and status
    localparam logic [7:0] CFG_PWM_SEL = 8'hE4;
    localparam logic [7:0] CFG_PWM_HIGH = 8'hE5;
    localparam logic [7:0] CFG_PWM_LOW = 8'hE6;
    localparam logic [7:0] CFG_PWM_BURST = 8'hE7;
    localparam logic [7:0] CFG_PORT_MODE = 8'hE8;
    localparam logic [7:0] CFG_DONE0 = 8'hEA;
    localparam logic [7:0] CFG_DONE1 = 8'hEB;
    localparam logic [7:0] CFG_GSTAT0 = 8'hEC;
    localparam logic [7:0] CFG_GSTAT1 = 8'hED;
    // Route register fields
    localparam int ROUTE_IRQ_LSB = 0;
    localparam int ROUTE_IRQ_W = 4;
    localparam int ROUTE_CONT_BIT = 4;
    // Sizes
    localparam int PORT_W = 8;
    localparam int PINS = 16;
    localparam int FILT_W = 9;
    // Reset values
    localparam logic [15:0] DIR_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [7:0] PERIOD_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [3:0] IRQSEL_RST = 4'h0;

    typedef enum logic [2:0] {
        PWM_IDLE = 3'b001,
        PWM_HIGH = 3'b010,
        PWM_LOW = 3'b100
    } pwm_state_t;
endpackage

// ### hw/dual_gpio_pwm_port.sv
// Two 8-bit GPIO ports with input interrupts, per-pin PWM and a status LED.
// Assumes host I/O and config accesses synchronous to clk; pins are asynchronous.
// What this block does
// - Sixteen pins as two 8-bit ports
// - Each port is GPIO or PWM outputs
// - Direction and data registers at documented ports
// - Direction bit n controls pin n alone
// - Per-pin mask selects interrupting inputs
// - Per-pin high or low trigger level
// - Interrupt only after condition outlasts programmed period
// - Selectable IRQ line, once or continuous
// - Interrupt registers in config space DC-E3
// - PWM pin runs continuous or counted burst
// - Separate high and low counts set frequency
// - Interrupt when a pulse burst completes
// - Port STATUS_INDICATOR_CONTROL bit 0 drives status LED
`timescale 1ns/1ps
module dual_gpio_pwm_port
    import gpio_pwm_pkg::*;
(
    input wire logic clk, // 25 MHz clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [15:0] ioAddr, // I/O port address
    input wire logic ioWr, // I/O write strobe
    input wire logic ioRd, // I/O read strobe
    input wire logic [7:0] ioWdata, // I/O write data
    output logic [7:0] ioRdata_q, // I/O read data, one cycle after ioRd
    input wire logic [7:0] cfgAddr, // Config space offset
    input wire logic cfgWr, // Config write strobe
    input wire logic cfgRd, // Config read strobe
    input wire logic [7:0] cfgWdata, // Config write data
    output logic [7:0] cfgRdata_q, // Config read data, one cycle after cfgRd
    input wire logic [15:0] pinIn, // Pin levels, asynchronous
    output logic [15:0] pinOut, // Pin drive values
    output logic [15:0] pinOe, // Pin output enables
    output logic [15:0] irqLines_q, // Interrupt request lines, level
    output logic statusLed_q // Status LED, high is on
);
    // ****************************************
    // Pin synchroniser
    // ****************************************
    logic [15:0] sync1_q, sync2_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    logic [15:0] data_q, data_d, dir_q, dir_d, mask_q, mask_d, level_q, level_d;
    logic [7:0] period_q [2], period_d [2];
    logic [3:0] irqSel_q [2], irqSel_d [2];
    logic [1:0] cont_q, cont_d, portPwm_q, portPwm_d;
    logic [3:0] pwmSel_q, pwmSel_d;
    logic [7:0] highCnt_q [PINS], highCnt_d [PINS], lowCnt_q [PINS], lowCnt_d [PINS];
    logic [7:0] burst_q [PINS], burst_d [PINS];
    logic [15:0] done_q, done_d, gstat_q, gstat_d, doneSet, gstatSet, qual, pwmStart, pwmWave;
    logic led_d;
    logic [7:0] ioRdata_d, cfgRdata_d;
    logic [15:0] pinMix;
    logic cfgP0, cfgP1;
    logic [1:0] cfgSub;

    assign pinMix = (dir_q & data_q) | (~dir_q & sync2_q);
    assign cfgP0 = cfgAddr[7:2] == CFG_P0_BASE[7:2];
    assign cfgP1 = cfgAddr[7:2] == CFG_P1_BASE[7:2];
    assign cfgSub = cfgAddr[1:0];

    always_comb begin
        data_d = data_q;
        dir_d = dir_q;
        mask_d = mask_q;
        level_d = level_q;
        period_d = period_q;
        irqSel_d = irqSel_q;
        cont_d = cont_q;
        portPwm_d = portPwm_q;
        pwmSel_d = pwmSel_q;
        highCnt_d = highCnt_q;
        lowCnt_d = lowCnt_q;
        burst_d = burst_q;
        led_d = statusLed_q;
        pwmStart = 16'h0000;
        done_d = done_q;
        gstat_d = gstat_q;
        ioRdata_d = ioRdata_q;
        cfgRdata_d = cfgRdata_q;
        if (ioWr) begin
            case (ioAddr)
                IO_DATA0: data_d[7:0] = ioWdata;
                IO_DATA1: data_d[15:8] = ioWdata;
                IO_DIR0: dir_d[7:0] = ioWdata;
                IO_DIR1: dir_d[15:8] = ioWdata;
                IO_LED: led_d = ioWdata[0];
                default: ;
            endcase
        end
        if (ioRd) begin
            case (ioAddr)
                IO_DATA0: ioRdata_d = pinMix[7:0];
                IO_DATA1: ioRdata_d = pinMix[15:8];
                IO_DIR0: ioRdata_d = dir_q[7:0];
                IO_DIR1: ioRdata_d = dir_q[15:8];
                default: ioRdata_d = 8'h00; // LED port is write-only
            endcase
        end
        if (cfgWr && (cfgP0 || cfgP1)) begin
            case (cfgSub)
                CFG_MASK: mask_d[cfgP1*8 +: 8] = cfgWdata;
                CFG_LEVEL: level_d[cfgP1*8 +: 8] = cfgWdata;
                CFG_PERIOD: period_d[cfgP1] = cfgWdata;
                default: begin
                    irqSel_d[cfgP1] = cfgWdata[ROUTE_IRQ_LSB +: ROUTE_IRQ_W];
                    cont_d[cfgP1] = cfgWdata[ROUTE_CONT_BIT];
                end
            endcase
        end else if (cfgWr) begin
            case (cfgAddr)
                CFG_PWM_SEL: pwmSel_d = cfgWdata[3:0];
                CFG_PWM_HIGH: highCnt_d[pwmSel_q] = cfgWdata;
                CFG_PWM_LOW: lowCnt_d[pwmSel_q] = cfgWdata;
                CFG_PWM_BURST: begin
                    burst_d[pwmSel_q] = cfgWdata;
                    pwmStart[pwmSel_q] = 1'b1;
                end
                CFG_PORT_MODE: portPwm_d = cfgWdata[1:0];
                CFG_DONE0: done_d[7:0] = done_q[7:0] & ~cfgWdata;
                CFG_DONE1: done_d[15:8] = done_q[15:8] & ~cfgWdata;
                CFG_GSTAT0: gstat_d[7:0] = gstat_q[7:0] & ~cfgWdata;
                CFG_GSTAT1: gstat_d[15:8] = gstat_q[15:8] & ~cfgWdata;
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle software clear
        done_d = done_d | doneSet;
        gstat_d = gstat_d | gstatSet;
        if (cfgRd) begin
            if (cfgP0 || cfgP1) begin
                case (cfgSub)
                    CFG_MASK: cfgRdata_d = mask_q[cfgP1*8 +: 8];
                    CFG_LEVEL: cfgRdata_d = level_q[cfgP1*8 +: 8];
                    CFG_PERIOD: cfgRdata_d = period_q[cfgP1];
                    default: cfgRdata_d = {3'h0, cont_q[cfgP1], irqSel_q[cfgP1]};
                endcase
            end else begin
                case (cfgAddr)
                    CFG_PWM_SEL: cfgRdata_d = {4'h0, pwmSel_q};
                    CFG_PWM_HIGH: cfgRdata_d = highCnt_q[pwmSel_q];
                    CFG_PWM_LOW: cfgRdata_d = lowCnt_q[pwmSel_q];
                    CFG_PWM_BURST: cfgRdata_d = burst_q[pwmSel_q];
                    CFG_PORT_MODE: cfgRdata_d = {6'h00, portPwm_q};
                    CFG_DONE0: cfgRdata_d = done_q[7:0];
                    CFG_DONE1: cfgRdata_d = done_q[15:8];
                    CFG_GSTAT0: cfgRdata_d = gstat_q[7:0];
                    CFG_GSTAT1: cfgRdata_d = gstat_q[15:8];
                    default: cfgRdata_d = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= DATA_RST;
            dir_q <= DIR_RST;
            mask_q <= MASK_RST;
            level_q <= LEVEL_RST;
            period_q <= '{PERIOD_RST, PERIOD_RST};
            irqSel_q <= '{IRQSEL_RST, IRQSEL_RST};
            cont_q <= 2'b00;
            portPwm_q <= 2'b00;
            pwmSel_q <= 4'h0;
            highCnt_q <= '{default: CNT_RST};
            lowCnt_q <= '{default: CNT_RST};
            burst_q <= '{default: CNT_RST};
            done_q <= 16'h0000;
            gstat_q <= 16'h0000;
            statusLed_q <= 1'b0;
            ioRdata_q <= 8'h00;
            cfgRdata_q <= 8'h00;
        end else begin
            data_q <= data_d;
            dir_q <= dir_d;
            mask_q <= mask_d;
            level_q <= level_d;
            period_q <= period_d;
            irqSel_q <= irqSel_d;
            cont_q <= cont_d;
            portPwm_q <= portPwm_d;
            pwmSel_q <= pwmSel_d;
            highCnt_q <= highCnt_d;
            lowCnt_q <= lowCnt_d;
            burst_q <= burst_d;
            done_q <= done_d;
            gstat_q <= gstat_d;
            statusLed_q <= led_d;
            ioRdata_q <= ioRdata_d;
            cfgRdata_q <= cfgRdata_d;
        end
    end

    // ****************************************
    // Per-pin input filter and PWM engine
    // ****************************************
    pwm_state_t pwmState_q [PINS];
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        localparam int P = i / PORT_W;
        logic [FILT_W-1:0] filt_q, filt_d;
        logic qual_q;
        pwm_state_t state_d;
        logic [7:0] timer_q, timer_d, remain_q, remain_d;
        logic isCont, match;

        assign match = mask_q[i] && (sync2_q[i] == level_q[i]);
        assign qual[i] = filt_q > {1'b0, period_q[P]};
        assign gstatSet[i] = qual[i] && !qual_q;
        assign isCont = burst_q[i] == 8'h00;

        always_comb begin
            filt_d = filt_q;
            if (!match) begin
                filt_d = '0;
            end else if (!(&filt_q)) begin
                filt_d = filt_q + 1'b1;
            end
            state_d = pwmState_q[i];
            timer_d = timer_q;
            remain_d = remain_q;
            doneSet[i] = 1'b0;
            case (pwmState_q[i])
                PWM_IDLE: begin
                    if (portPwm_q[P] && (isCont || remain_q != 8'h00)) begin
                        state_d = PWM_HIGH;
                        timer_d = highCnt_q[i];
                    end
                end
                PWM_HIGH: begin
                    if (timer_q != 8'h00) begin
                        timer_d = timer_q - 1'b1;
                    end else begin
                        state_d = PWM_LOW;
                        timer_d = lowCnt_q[i];
                    end
                end
                PWM_LOW: begin
                    if (timer_q != 8'h00) begin
                        timer_d = timer_q - 1'b1;
                    end else if (isCont) begin
                        state_d = PWM_HIGH;
                        timer_d = highCnt_q[i];
                    end else begin
                        remain_d = remain_q - 1'b1;
                        state_d = (remain_q == 8'h01) ? PWM_IDLE : PWM_HIGH;
                        doneSet[i] = remain_q == 8'h01;
                        timer_d = highCnt_q[i];
                    end
                end
                default: state_d = PWM_IDLE;
            endcase
            // A burst write restarts the pin, so that a half-run pulse is not counted
            if (pwmStart[i]) begin
                remain_d = burst_d[i];
            end
            if (!portPwm_q[P] || pwmStart[i]) begin
                state_d = PWM_IDLE;
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                filt_q <= '0;
                qual_q <= 1'b0;
                pwmState_q[i] <= PWM_IDLE;
                timer_q <= 8'h00;
                remain_q <= 8'h00;
            end else begin
                filt_q <= filt_d;
                qual_q <= qual[i];
                pwmState_q[i] <= state_d;
                timer_q <= timer_d;
                remain_q <= remain_d;
            end
        end

        assign pwmWave[i] = pwmState_q[i] == PWM_HIGH;
        // PWM mode forces the pin to drive; GPIO follows its direction bit
        assign pinOe[i] = portPwm_q[P] | dir_q[i];
        assign pinOut[i] = portPwm_q[P] ? pwmWave[i] : data_q[i];
    end

    // ****************************************
    // Interrupt routing
    // ****************************************
    logic [15:0] irqLines_d;
    logic [1:0] portReq;
    always_comb begin
        irqLines_d = 16'h0000;
        for (int p = 0; p < 2; p++) begin
            // Once mode holds a latched event, continuous follows the live condition
            portReq[p] = (cont_q[p] ? |qual[p*8 +: 8] : |gstat_q[p*8 +: 8]) | (|done_q[p*8 +: 8]);
            irqLines_d[irqSel_q[p]] = irqLines_d[irqSel_q[p]] | portReq[p];
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqLines_q <= 16'h0000;
        end else begin
            irqLines_q <= irqLines_d;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence ledWrite_s;
        ioWr && ioAddr == IO_LED;
    endsequence
    ledWrite_a: assert property (ledWrite_s |=> statusLed_q == $past(ioWdata[0]))
        else $error("status LED did not follow write");
    dirWrite_a: assert property (ioWr && ioAddr == IO_DIR0 |=> dir_q[7:0] == $past(ioWdata))
        else $error("port 0 direction not written");
    readMix_a: assert property (ioRd && ioAddr == IO_DATA0 |=> ioRdata_q == $past(pinMix[7:0]))
        else $error("data read is not pin/latch mix");
    oeGpio_a: assert property (!portPwm_q[0] |-> pinOe[7:0] == dir_q[7:0])
        else $error("GPIO enable differs from direction");
    filterHold_a: assert property ($rose(qual[8]) |-> $past(mask_q[8] && sync2_q[8] == level_q[8]))
        else $error("interrupt qualified without held level");
    onceIrq_a: assert property ($rose(gstat_q[8]) && !cont_q[1] |=> irqLines_q[$past(irqSel_q[1])])
        else $error("latched event not routed to IRQ");
    pwmWave_a: assert property (portPwm_q[0] && $rose(pinOut[2]) |-> g_pin[2].timer_q == $past(highCnt_q[2]))
        else $error("PWM high phase not loaded from high count");
    burstDone_a: assert property ($rose(done_q[2]) |-> $past(pwmState_q[2] == PWM_LOW) ##0 pwmState_q[2] == PWM_IDLE)
        else $error("burst done without final low phase");
    resetMask_a: assert property ($rose(arst_n) |-> mask_q == MASK_RST && dir_q == DIR_RST)
        else $error("mask or direction not cleared by reset");
endmodule // dual_gpio_pwm_port

// ### sim/pin_load_model.sv
// Behavioural model of the loads and signal sources wired to the sixteen pins.
// Assumes the bench selects which pins an external source drives and with what level.
`timescale 1ns/1ps
module pin_load_model (
    input wire logic [15:0] pinOut, // Drive values from the port block
    input wire logic [15:0] pinOe, // Output enables from the port block
    input wire logic [15:0] extEn, // Pins driven by an external source
    input wire logic [15:0] extVal, // Level of the external source
    output logic [15:0] pinIn // Resolved pin levels
);
    // ****************************************
    // Pin resolution
    // ****************************************
    // An undriven input sits at its pull-up, never at a stale value
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pinOe[i] === 1'b1)
                pinIn[i] = pinOut[i];
            else if (extEn[i])
                pinIn[i] = extVal[i];
            else
                pinIn[i] = 1'b1;
        end
    end
endmodule // pin_load_model

// ### sim/dual_gpio_pwm_port_tb.sv
// Self-checking bench for the dual GPIO/PWM port block.
// Assumes the package constants and the pin load model; host accesses are one-cycle strobes.
`timescale 1ns/1ps
module dual_gpio_pwm_port_tb;
    import gpio_pwm_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] ioAddr = 16'h0000;
    logic ioWr = 1'b0;
    logic ioRd = 1'b0;
    logic [7:0] ioWdata = 8'h00;
    logic [7:0] ioRdata_q;
    logic [7:0] cfgAddr = 8'h00;
    logic cfgWr = 1'b0;
    logic cfgRd = 1'b0;
    logic [7:0] cfgWdata = 8'h00;
    logic [7:0] cfgRdata_q;
    logic [15:0] pinIn;
    logic [15:0] pinOut;
    logic [15:0] pinOe;
    logic [15:0] irqLines_q;
    logic statusLed_q;
    logic [15:0] extEn = 16'h0000;
    logic [15:0] extVal = 16'h0000;
    int n_fail = 0;
    int checks = 0;
    int highs;
    int rises;

    always #20 clk = ~clk;

    dual_gpio_pwm_port dut_u (.clk(clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
        .ioWdata(ioWdata), .ioRdata_q(ioRdata_q), .cfgAddr(cfgAddr), .cfgWr(cfgWr), .cfgRd(cfgRd),
        .cfgWdata(cfgWdata), .cfgRdata_q(cfgRdata_q), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .irqLines_q(irqLines_q), .statusLed_q(statusLed_q));
    pin_load_model load_u (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extVal(extVal), .pinIn(pinIn));

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic stop_test;
        if (n_fail == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input logic cfg, input logic isWr, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] r);
        @(posedge clk);
        #1;
        if (cfg) begin
            cfgAddr = a[7:0];
            cfgWdata = d;
            cfgWr = isWr;
            cfgRd = ~isWr;
        end else begin
            ioAddr = a;
            ioWdata = d;
            ioWr = isWr;
            ioRd = ~isWr;
        end
        @(posedge clk);
        #1;
        {ioWr, ioRd, cfgWr, cfgRd} = 4'h0;
        r = cfg ? cfgRdata_q : ioRdata_q;
    endtask

    task automatic wr(input logic cfg, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(cfg, 1'b1, a, d, r);
    endtask

    task automatic rdc(input logic cfg, input logic [15:0] a, input logic [7:0] e, input string what);
        logic [7:0] r;
        xfer(cfg, 1'b0, a, 8'h00, r);
        check({8'h00, r}, {8'h00, e}, what);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Counts high cycles and rising edges of PWM pin 2
    task automatic pwm_count(input int n);
        logic prev;
        highs = 0;
        rises = 0;
        prev = pinOut[2];
        repeat (n) begin
            @(posedge clk);
            #1;
            if (pinOut[2] === 1'b1)
                highs++;
            if (pinOut[2] === 1'b1 && prev === 1'b0)
                rises++;
            prev = pinOut[2];
        end
    endtask

    function automatic logic [15:0] p1(input logic [1:0] k);
        return {8'h00, CFG_P1_BASE + {6'h00, k}};
    endfunction

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1'b1;
        check({pinOe[15:1], statusLed_q}, 16'h0000, "outputs after reset");
        rdc(1'b0, IO_DIR0, 8'h00, "dir0 reset");
        rdc(1'b0, IO_DIR1, 8'h00, "dir1 reset");
        rdc(1'b1, {8'h00, CFG_P0_BASE}, 8'h00, "mask0 reset");
        rdc(1'b1, p1(CFG_MASK), 8'h00, "mask1 reset");
        // Direction and data, both ports
        wr(1'b0, IO_DIR0, 8'h0F);
        check(pinOe, 16'h000F, "dir0 0F");
        wr(1'b0, IO_DIR1, 8'hF0);
        check(pinOe, 16'hF00F, "dir1 F0");
        wr(1'b0, IO_DATA0, 8'hA5);
        wr(1'b0, IO_DATA1, 8'h3C);
        extEn = 16'h00F0;
        extVal = 16'h0030;
        wait_cyc(3);
        check({12'h000, pinOut[3:0]}, 16'h0005, "port0 drive");
        check({12'h000, pinOut[15:12]}, 16'h0003, "port1 drive");
        rdc(1'b0, IO_DATA0, 8'h35, "data0 mixed");
        rdc(1'b0, IO_DATA1, 8'h3F, "data1 mixed");
        rdc(1'b0, IO_DIR0, 8'h0F, "dir0 readback");
        rdc(1'b0, 16'h0077, 8'h00, "unmapped read");
        // Status LED, write only
        wr(1'b0, IO_LED, 8'h01);
        check({15'h0000, statusLed_q}, 16'h0001, "led on");
        rdc(1'b0, IO_LED, 8'h00, "led reads 0");
        wr(1'b0, IO_LED, 8'h00);
        check({15'h0000, statusLed_q}, 16'h0000, "led off");
        // Port 1 pin 8 interrupt, low level, once mode on IRQ 5
        extEn = 16'h0000;
        wr(1'b0, IO_DIR1, 8'h00);
        wr(1'b1, p1(CFG_MASK), 8'h01);
        wr(1'b1, p1(CFG_LEVEL), 8'h00);
        wr(1'b1, p1(CFG_PERIOD), 8'h03);
        wr(1'b1, p1(CFG_ROUTE), 8'h05);
        wait_cyc(4);
        check(irqLines_q, 16'h0000, "idle high pin");
        extEn = 16'h0100;
        extVal = 16'h0000;
        wait_cyc(6);
        check(irqLines_q, 16'h0000, "before period");
        wait_cyc(8);
        check(irqLines_q, 16'h0020, "once raised");
        extEn = 16'h0000;
        wait_cyc(10);
        check(irqLines_q, 16'h0020, "once sticky");
        rdc(1'b1, {8'h00, CFG_GSTAT1}, 8'h01, "event status");
        wr(1'b1, {8'h00, CFG_GSTAT1}, 8'h01);
        wait_cyc(2);
        check(irqLines_q, 16'h0000, "once cleared");
        // Continuous mode on IRQ 12
        wr(1'b1, p1(CFG_ROUTE), 8'h1C);
        rdc(1'b1, p1(CFG_ROUTE), 8'h1C, "route readback");
        extEn = 16'h0100;
        wait_cyc(14);
        check(irqLines_q, 16'h1000, "cont raised");
        extEn = 16'h0000;
        wait_cyc(6);
        check(irqLines_q, 16'h0000, "cont follows pin");
        // High level triggers off the pull-up, then masking silences it
        wr(1'b1, p1(CFG_LEVEL), 8'h01);
        wait_cyc(14);
        check(irqLines_q, 16'h1000, "high level");
        wr(1'b1, p1(CFG_MASK), 8'h00);
        wait_cyc(6);
        check(irqLines_q, 16'h0000, "masked");
        wr(1'b1, {8'h00, CFG_GSTAT1}, 8'hFF);
        // PWM burst of 3 on pin 2, high 3 cycles, low 2 cycles, done on IRQ 3
        wr(1'b1, {8'h00, CFG_P0_BASE + 8'h03}, 8'h03);
        wr(1'b1, {8'h00, CFG_PORT_MODE}, 8'h03);
        check(pinOe, 16'hFFFF, "pwm ports drive");
        wr(1'b1, {8'h00, CFG_PWM_SEL}, 8'h02);
        wr(1'b1, {8'h00, CFG_PWM_HIGH}, 8'h02);
        wr(1'b1, {8'h00, CFG_PWM_LOW}, 8'h01);
        wr(1'b1, {8'h00, CFG_PWM_BURST}, 8'h03);
        pwm_count(40);
        check(16'(highs), 16'h0009, "burst high cycles");
        check(16'(rises), 16'h0003, "burst pulses");
        rdc(1'b1, {8'h00, CFG_DONE0}, 8'h04, "done bit");
        check(irqLines_q, 16'h0008, "done irq");
        wr(1'b1, {8'h00, CFG_DONE0}, 8'h04);
        wait_cyc(2);
        check(irqLines_q, 16'h0000, "done cleared");
        // Continuous waveform, period of 5 cycles
        wr(1'b1, {8'h00, CFG_PWM_BURST}, 8'h00);
        pwm_count(40);
        check({15'h0000, rises > 6 && rises < 9}, 16'h0001, "continuous pulses");
        wr(1'b1, {8'h00, CFG_PORT_MODE}, 8'h00);
        check(pinOe, 16'h000F, "back to gpio");
        stop_test();
    end
endmodule // dual_gpio_pwm_port_tb
